// [inc/mer_pkg.sv]
// shared constants for the motion and event report register block
package mer_pkg;

  // register port geometry
  localparam int             MER_AW             = 7;      // register address width
  localparam int             MER_DW             = 8;      // register data width

  // register offsets on the serial register port
  localparam logic [MER_AW-1:0] ADDR_EVENT      = 7'h02;  // event_flags
  localparam logic [MER_AW-1:0] ADDR_XDISP      = 7'h03;  // x_displacement
  localparam logic [MER_AW-1:0] ADDR_YDISP      = 7'h04;  // y_displacement
  localparam logic [MER_AW-1:0] ADDR_SURF_QUAL  = 7'h05;  // surface_quality
  localparam logic [MER_AW-1:0] ADDR_EXP_HI     = 7'h06;  // exposure_high
  localparam logic [MER_AW-1:0] ADDR_EXP_LO     = 7'h07;  // exposure_low
  localparam logic [MER_AW-1:0] ADDR_PIX_GRAB   = 7'h0B;  // pixel grab, decoded only
  localparam logic [MER_AW-1:0] ADDR_BUTTON_ST  = 7'h12;  // button status, decoded only
  localparam logic [MER_AW-1:0] ADDR_FINGER_ST  = 7'h7A;  // finger_presence_state_reg
  localparam logic [MER_AW-1:0] ADDR_SOFT_TAP_ST = 7'h7F; // soft_tap_state_reg

  // event_flags bit positions
  localparam int             EVT_MOTION_BIT     = 7;      // motion_pending
  localparam int             EVT_PIX_RDY_BIT    = 6;      // pixel_byte_ready
  localparam int             EVT_FIRST_PIX_BIT  = 5;      // first_pixel_flag
  localparam int             EVT_ACCUM_OVERFLOW_BIT       = 4;      // accum_overflow
  localparam int             EVT_RESET_BIT      = 3;      // reset_seen_flag
  localparam int             EVT_BUTTON_BIT     = 2;      // button_click_flag
  localparam int             EVT_SOFT_BIT       = 1;      // soft click flag
  localparam int             EVT_FINGER_BIT     = 0;      // finger_change_flag

  // sticky flag slots, one generate entry each
  localparam int             FLAG_FINGER        = 0;
  localparam int             FLAG_SOFT          = 1;
  localparam int             FLAG_BUTTON        = 2;
  localparam int             FLAG_RESET         = 3;
  localparam int             FLAG_FIRST_PIX     = 4;
  localparam int             NUM_FLAGS          = 5;

  // reset values
  localparam logic [MER_DW-1:0] RDATA_RST       = 8'h00;  // read data after reset
  localparam logic [MER_DW-1:0] UNMAPPED_RDATA  = 8'h00;  // answer to unmapped reads
  localparam logic           RESET_SEEN_RST     = 1'b1;   // reset leaves its own mark
  localparam logic           FLAG_RST           = 1'b0;   // other flags start clear

  // value limits
  localparam logic [MER_DW-1:0] SURF_QUAL_MAX   = 8'hA7;  // surface quality ceiling
  localparam int             ACC_W_DEFAULT      = 16;     // internal accumulator width
  localparam int             NUM_AXES           = 2;      // x and y
  localparam int             READ_LATENCY       = 1;      // cycles from read to data

endpackage : mer_pkg

// [design/mer_sticky_flag.sv]
// one sticky event flag with set priority over clear
`timescale 1ns/1ps
`default_nettype none
module mer_sticky_flag #(
  parameter logic RST_VAL = 1'b0                // value taken during reset
) (
  input  wire logic mclk,                        // system clock
  input  wire logic sys_rst,                     // synchronous reset, active high
  input  wire logic clk_en,                      // freezes the flag while low
  input  wire logic set_in,                      // event pulse
  input  wire logic clr_in,                      // clear pulse
  output logic      flag                         // flag level
);

  // set wins so an event in the clearing cycle is never lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag <= RST_VAL;
    end else if (clk_en) begin
      if (set_in) begin
        flag <= 1'b1;
      end else if (clr_in) begin
        flag <= 1'b0;
      end
    end
  end

endmodule : mer_sticky_flag
`default_nettype wire

// [design/mer_axis_accum.sv]
// saturating motion accumulator for one axis with subtract-on-read report
`timescale 1ns/1ps
`default_nettype none
module mer_axis_accum #(
  parameter int ACC_W = 16                       // accumulator width, 9 to 24
) (
  input  wire logic              mclk,           // system clock
  input  wire logic              sys_rst,        // synchronous reset, active high
  input  wire logic              clk_en,         // freezes state while low
  input  wire logic signed [7:0] delta_in,       // new counts, resolution applied
  input  wire logic              delta_vld,      // delta_in valid this cycle
  input  wire logic              report_rd,      // host reads the report
  input  wire logic              clear_all,      // event register written
  output logic signed [7:0]      report,         // clamped report value
  output logic                   nonzero,        // motion still held
  output logic                   full_scale,     // accumulator at a rail
  output logic                   ovf_pulse       // saturation this cycle
);

  localparam logic signed [ACC_W:0]   SUM_MAX = {2'b00, {(ACC_W-1){1'b1}}}; // positive rail
  localparam logic signed [ACC_W:0]   SUM_MIN = {2'b11, {(ACC_W-1){1'b0}}}; // negative rail
  localparam logic signed [ACC_W-1:0] REP_MAX = ACC_W'(127);                // report ceiling
  localparam logic signed [ACC_W-1:0] REP_MIN = ACC_W'(-128);               // report floor

  generate
    if (ACC_W < 9 || ACC_W > 24) begin : g_bad_width
      $error("mer_axis_accum: ACC_W must be 9 to 24");
    end
  endgenerate

  logic signed [ACC_W-1:0] acc_reg;              // running sum
  logic signed [ACC_W:0]   sum;                  // one guard bit for saturation
  logic signed [ACC_W-1:0] acc_next;             // next sum after saturation

  // wider than the report so large moves survive between reads
  always_comb begin
    sum = {acc_reg[ACC_W-1], acc_reg};
    if (clear_all) begin
      sum = '0;
    end else if (report_rd) begin
      sum = sum - {{(ACC_W+1-8){report[7]}}, report};
    end
    if (delta_vld) begin
      sum = sum + {{(ACC_W+1-8){delta_in[7]}}, delta_in};
    end
    ovf_pulse = 1'b0;
    if (sum > SUM_MAX) begin
      acc_next  = SUM_MAX[ACC_W-1:0];
      ovf_pulse = 1'b1;
    end else if (sum < SUM_MIN) begin
      acc_next  = SUM_MIN[ACC_W-1:0];
      ovf_pulse = 1'b1;
    end else begin
      acc_next = sum[ACC_W-1:0];
    end
  end

  // state update
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_reg <= '0;
    end else if (clk_en) begin
      acc_reg <= acc_next;
    end
  end

  // report is the portion that fits, the rest waits for later reads
  always_comb begin
    if (acc_reg > REP_MAX) begin
      report = 8'sh7F;
    end else if (acc_reg < REP_MIN) begin
      report = 8'sh80;
    end else begin
      report = acc_reg[7:0];
    end
  end

  assign nonzero    = (acc_reg != '0);
  assign full_scale = (acc_reg == SUM_MAX[ACC_W-1:0]) || (acc_reg == SUM_MIN[ACC_W-1:0]);

endmodule : mer_axis_accum
`default_nettype wire

// [design/mer_motion_event_regs.sv]
// motion and event report registers of the finger navigation sensor
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - event flags record events since last clear
// - event write clears motion, overflow, displacements
// - per-axis accumulators wider than eight bits
// - accumulator overflow sets the overflow flag
// - overflow clears after readout leaves rails
// - motion flag high while displacement pending
// - pixel ready shows a valid pixel byte
// - first pixel flag on grab write, wrap
// - reset flag set by reset, event write clears
// - button flag cleared by button status read
// - soft click flag cleared by status read
// - finger change flag cleared by status read
// - x displacement clamped, read subtracts the reported part
// - y displacement clamped, read subtracts the reported part
// - surface quality upper bits, at most 167
// - exposure split high and low bytes
// - registers reachable over the register port
module mer_motion_event_regs
  import mer_pkg::*;
#(
  parameter int ACC_W = mer_pkg::ACC_W_DEFAULT   // accumulator width per axis
) (
  input  wire logic                      mclk,              // system clock
  input  wire logic                      sys_rst,           // synchronous reset
  input  wire logic                      clk_en,            // freezes all state while low
  input  wire logic [mer_pkg::MER_AW-1:0] reg_addr,         // register address
  input  wire logic                      reg_rd,            // read strobe
  input  wire logic                      reg_wr,            // write strobe, data discarded
  output logic      [mer_pkg::MER_DW-1:0] reg_rdata,        // read data
  output logic                           reg_rvalid,        // read data valid
  input  wire logic                      motion_vld,        // new deltas valid
  input  wire logic signed [7:0]         delta_x_in,        // x counts this frame
  input  wire logic signed [7:0]         delta_y_in,        // y counts this frame
  input  wire logic [8:0]                feature_count,     // valid features this frame
  input  wire logic [15:0]               exposure_in,       // exposure in clock cycles
  input  wire logic                      pixel_byte_ready,  // pixel byte available
  input  wire logic                      pixel_wrap,        // pointer wrapped to 0,0
  input  wire logic                      button_click_evt,  // button click pulse
  input  wire logic                      soft_click_evt,    // soft click pulse
  input  wire logic                      finger_present,    // finger on the window
  input  wire logic                      int_reset_evt,     // internal reset pulse
  output logic                           pixel_grab_wr,     // grab register was written
  output logic                           pixel_grab_rd,     // grab register was read
  output logic                           motion_pending,    // displacement waiting
  output logic                           accum_overflow     // motion path lost
);

  import mer_pkg::*;

  // register port decode
  logic rd_event;                                // event register read
  logic rd_x;                                    // x displacement read
  logic rd_y;                                    // y displacement read
  logic rd_exp_hi;                               // exposure high read
  logic wr_event;                                // event register written
  logic wr_grab;                                 // pixel grab written
  logic rd_grab;                                 // pixel grab read

  // a write is ignored if a read shares the cycle
  assign rd_event  = reg_rd && (reg_addr == ADDR_EVENT);
  assign rd_x      = reg_rd && (reg_addr == ADDR_XDISP);
  assign rd_y      = reg_rd && (reg_addr == ADDR_YDISP);
  assign rd_exp_hi = reg_rd && (reg_addr == ADDR_EXP_HI);
  assign rd_grab   = reg_rd && (reg_addr == ADDR_PIX_GRAB);
  assign wr_event  = reg_wr && !reg_rd && (reg_addr == ADDR_EVENT);
  assign wr_grab   = reg_wr && !reg_rd && (reg_addr == ADDR_PIX_GRAB);

  // per-axis accumulators
  logic signed [7:0]      axis_delta [NUM_AXES];   // delta per axis
  logic                   axis_rd    [NUM_AXES];   // read strobe per axis
  logic signed [7:0]      axis_rep   [NUM_AXES];   // clamped report per axis
  logic [NUM_AXES-1:0]    axis_nz;                 // motion held per axis
  logic [NUM_AXES-1:0]    axis_full;               // rail reached per axis
  logic [NUM_AXES-1:0]    axis_ovf;                // saturation pulse per axis

  assign axis_delta[0] = delta_x_in;
  assign axis_delta[1] = delta_y_in;
  assign axis_rd[0]    = rd_x;
  assign axis_rd[1]    = rd_y;

  // both axes share one structure; write clears both
  generate
    for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
      mer_axis_accum #(
        .ACC_W      (ACC_W)
      ) u_accum (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .delta_in   (axis_delta[a]),
        .delta_vld  (motion_vld),
        .report_rd  (axis_rd[a]),
        .clear_all  (wr_event),
        .report     (axis_rep[a]),
        .nonzero    (axis_nz[a]),
        .full_scale (axis_full[a]),
        .ovf_pulse  (axis_ovf[a])
      );
    end
  endgenerate

  // motion flag drops exactly when both sums are emptied
  assign motion_pending = |axis_nz;

  // overflow tracking
  logic accum_overflow_reg;                                // accum_overflow state
  logic accum_overflow_read_seen;                          // displacement read since overflow

  // new saturation beats any clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      accum_overflow_reg <= 1'b0;
    end else if (clk_en) begin
      if (|axis_ovf) begin
        accum_overflow_reg <= 1'b1;
      end else if (wr_event) begin
        accum_overflow_reg <= 1'b0;
      end else if (accum_overflow_read_seen && !(|axis_full)) begin
        accum_overflow_reg <= 1'b0;
      end
    end
  end

  // remembers that some motion has been drained since the overflow
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      accum_overflow_read_seen <= 1'b0;
    end else if (clk_en) begin
      if (|axis_ovf || !accum_overflow_reg) begin
        accum_overflow_read_seen <= 1'b0;
      end else if (rd_x || rd_y) begin
        accum_overflow_read_seen <= 1'b1;
      end
    end
  end

  assign accum_overflow = accum_overflow_reg;

  // finger state change detect
  logic finger_prev;                             // last finger state
  logic finger_edge;                             // state changed this cycle

  // input comes from on-chip logic on mclk, so no synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      finger_prev <= finger_present;             // follow the pin so reset leaves no false edge
    end else if (clk_en) begin
      finger_prev <= finger_present;
    end
  end

  // both on-to-off and off-to-on count
  assign finger_edge = (finger_present != finger_prev);

  // sticky event flags
  logic [NUM_FLAGS-1:0] flag_set;                // set pulse per flag
  logic [NUM_FLAGS-1:0] flag_clr;                // clear pulse per flag
  logic [NUM_FLAGS-1:0] flags;                   // flag levels

  assign flag_set[FLAG_FINGER]    = finger_edge;
  assign flag_clr[FLAG_FINGER]    = reg_rd && (reg_addr == ADDR_FINGER_ST);
  assign flag_set[FLAG_SOFT]      = soft_click_evt;
  assign flag_clr[FLAG_SOFT]      = reg_rd && (reg_addr == ADDR_SOFT_TAP_ST);
  assign flag_set[FLAG_BUTTON]    = button_click_evt;
  assign flag_clr[FLAG_BUTTON]    = reg_rd && (reg_addr == ADDR_BUTTON_ST);
  assign flag_set[FLAG_RESET]     = int_reset_evt;
  assign flag_clr[FLAG_RESET]     = wr_event;
  assign flag_set[FLAG_FIRST_PIX] = wr_grab || pixel_wrap;
  assign flag_clr[FLAG_FIRST_PIX] = rd_grab;

  // only the reset flag comes out of reset set
  generate
    for (genvar f = 0; f < NUM_FLAGS; f++) begin : g_flag
      mer_sticky_flag #(
        .RST_VAL (f == FLAG_RESET ? RESET_SEEN_RST : FLAG_RST)
      ) u_flag (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .set_in  (flag_set[f]),
        .clr_in  (flag_clr[f]),
        .flag    (flags[f])
      );
    end
  endgenerate

  // event register image
  logic [MER_DW-1:0] event_image;                // assembled event byte

  always_comb begin
    event_image                    = '0;
    event_image[EVT_MOTION_BIT]    = motion_pending;
    event_image[EVT_PIX_RDY_BIT]   = pixel_byte_ready;
    event_image[EVT_FIRST_PIX_BIT] = flags[FLAG_FIRST_PIX];
    event_image[EVT_ACCUM_OVERFLOW_BIT]      = accum_overflow_reg;
    event_image[EVT_RESET_BIT]     = flags[FLAG_RESET];
    event_image[EVT_BUTTON_BIT]    = flags[FLAG_BUTTON];
    event_image[EVT_SOFT_BIT]      = flags[FLAG_SOFT];
    event_image[EVT_FINGER_BIT]    = flags[FLAG_FINGER];
  end

  // surface quality, registered every cycle
  logic [MER_DW-1:0] surf_qual_reg;              // surface_quality
  logic [MER_DW-1:0] surf_qual_next;             // upper bits, clipped

  // clip guards against a counter glitch above the ceiling
  assign surf_qual_next = (feature_count[8:1] > SURF_QUAL_MAX) ? SURF_QUAL_MAX : feature_count[8:1];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      surf_qual_reg <= '0;
    end else if (clk_en) begin
      surf_qual_reg <= surf_qual_next;
    end
  end

  // exposure low byte captured with the high byte read
  logic [7:0] exp_low_hold;                      // matched low byte

  // a frame update between the two reads cannot tear the value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exp_low_hold <= '0;
    end else if (clk_en && rd_exp_hi) begin
      exp_low_hold <= exposure_in[7:0];
    end
  end

  // read data mux, one cycle latency
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= RDATA_RST;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        ADDR_EVENT:     reg_rdata <= event_image;
        ADDR_XDISP:     reg_rdata <= axis_rep[0];
        ADDR_YDISP:     reg_rdata <= axis_rep[1];
        ADDR_SURF_QUAL: reg_rdata <= surf_qual_reg;
        ADDR_EXP_HI:    reg_rdata <= exposure_in[15:8];
        ADDR_EXP_LO:    reg_rdata <= exp_low_hold;
        default:        reg_rdata <= UNMAPPED_RDATA;              // registers held elsewhere
      endcase
    end
  end

  // valid marks the answer one cycle after the read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
    end
  end

  // strobes to the pixel grab logic, which owns the pointer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pixel_grab_wr <= 1'b0;
      pixel_grab_rd <= 1'b0;
    end else if (clk_en) begin
      pixel_grab_wr <= wr_grab;
      pixel_grab_rd <= rd_grab;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read not answered in one cycle");
  chk_write_clears: assert property (clk_en && wr_event && !motion_vld |=> !motion_pending && !accum_overflow)
    else $error("event write left motion or overflow");
  chk_ovf_sets: assert property (clk_en && (|axis_ovf) |=> accum_overflow)
    else $error("overflow flag not set");
  chk_x_value: assert property (clk_en && rd_x |=> reg_rdata == $past(axis_rep[0]))
    else $error("x displacement read wrong");
  chk_y_value: assert property (clk_en && rd_y |=> reg_rdata == $past(axis_rep[1]))
    else $error("y displacement read wrong");
  chk_surf_max: assert property (surf_qual_reg <= SURF_QUAL_MAX)
    else $error("surface quality above ceiling");
  chk_exp_hold: assert property (clk_en && rd_exp_hi |=> exp_low_hold == $past(exposure_in[7:0]))
    else $error("exposure low byte not captured");
  chk_finger_flag: assert property (clk_en && finger_edge |=> flags[FLAG_FINGER])
    else $error("finger change not flagged");
  chk_button_flag: assert property (clk_en && button_click_evt |=> flags[FLAG_BUTTON])
    else $error("button click not flagged");
  chk_motion_bit: assert property (clk_en && rd_event |=> reg_rdata[EVT_MOTION_BIT] == $past(motion_pending))
    else $error("motion bit mismatch");
  chk_reset_flag: assert property (clk_en && int_reset_evt |=> flags[FLAG_RESET])
    else $error("internal reset not flagged");
  chk_first_pixel: assert property (clk_en && (pixel_wrap || wr_grab) |=> flags[FLAG_FIRST_PIX])
    else $error("first pixel flag not set");
  chk_ovf_release: assert property (accum_overflow && clk_en && accum_overflow_read_seen
                                    && !(|axis_full) && !(|axis_ovf) |=> !accum_overflow)
    else $error("overflow not released");

  // read port answers only what was asked
  chk_rvalid_idle: assert property (clk_en && !reg_rd |=> !reg_rvalid)
    else $error("valid without a read");
  chk_pixel_byte_ready_bit: assert property (clk_en && rd_event
                                   |=> reg_rdata[EVT_PIX_RDY_BIT] == $past(pixel_byte_ready))
    else $error("pixel ready bit mismatch");

  // exposure bytes, the low one from the hold register
  chk_exp_high_read: assert property (clk_en && rd_exp_hi |=> reg_rdata == $past(exposure_in[15:8]))
    else $error("exposure high byte wrong");
  chk_exp_low_read: assert property (clk_en && reg_rd && (reg_addr == ADDR_EXP_LO)
                                     |=> reg_rdata == $past(exp_low_hold))
    else $error("exposure low byte not from hold");

  // soft flag set, flag clears only when no new event races them, grab write strobe
  chk_soft_flag: assert property (clk_en && soft_click_evt |=> flags[FLAG_SOFT])
    else $error("soft click not flagged");
  chk_soft_clear: assert property (clk_en && flag_clr[FLAG_SOFT] && !soft_click_evt |=> !flags[FLAG_SOFT])
    else $error("soft click flag not cleared");
  chk_button_clear: assert property (clk_en && flag_clr[FLAG_BUTTON] && !button_click_evt
                                     |=> !flags[FLAG_BUTTON])
    else $error("button flag not cleared");
  chk_finger_clear: assert property (clk_en && flag_clr[FLAG_FINGER] && !finger_edge
                                     |=> !flags[FLAG_FINGER])
    else $error("finger flag not cleared");
  chk_reset_clear: assert property (clk_en && wr_event && !int_reset_evt |=> !flags[FLAG_RESET])
    else $error("reset flag not cleared by write");
  chk_grab_strobe: assert property (clk_en && wr_grab |=> pixel_grab_wr)
    else $error("grab write strobe missing");

  // enable low must hold every recorded event
  chk_freeze_state: assert property (!clk_en |=> $stable(flags) && $stable(accum_overflow))
    else $error("state moved with enable low");

  // main scenarios the bench should reach
  cov_overflow_cleared: cover property (accum_overflow ##[1:200] !accum_overflow);
  cov_motion_drain: cover property (rd_event ##2 rd_x ##2 rd_y ##1 !motion_pending);
  cov_exposure_pair: cover property (rd_exp_hi ##[1:4] (reg_rd && reg_addr == ADDR_EXP_LO));
  cov_button_cleared: cover property (flags[FLAG_BUTTON] && flag_clr[FLAG_BUTTON] ##1 !flags[FLAG_BUTTON]);
  cov_enable_freeze: cover property (!clk_en && motion_vld);

endmodule : mer_motion_event_regs
`default_nettype wire

// [tb/mer_host_model.sv]
// host model driving the register port of the report block
`timescale 1ns/1ps
`default_nettype none
module mer_host_model
  import mer_pkg::*;
(
  input  wire logic                       mclk,       // system clock
  output logic      [mer_pkg::MER_AW-1:0] reg_addr,   // register address
  output logic                            reg_rd,     // read strobe
  output logic                            reg_wr,     // write strobe
  input  wire logic [mer_pkg::MER_DW-1:0] reg_rdata,  // read data
  input  wire logic                       reg_rvalid  // read data valid
);
  initial begin
    reg_addr = '0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  end
  // one read; a missing valid turns the data unknown so compares fail
  task automatic rd(input logic [MER_AW-1:0] a, output logic [MER_DW-1:0] q);
    @(posedge mclk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
  // one write, data is not ported
  task automatic wr(input logic [MER_AW-1:0] a);
    @(posedge mclk) reg_addr <= a;
    reg_wr <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : wr
  // event first, then x and y back to back, until motion clears
  task automatic drain(output int s);
    logic [7:0] q;
    s = 0;
    for (int i = 0; i < 32; i++) begin
      rd(ADDR_EVENT, q);
      if (q[EVT_MOTION_BIT] !== 1'b1) break;
      rd(ADDR_XDISP, q);
      s += int'($signed(q));
      rd(ADDR_YDISP, q);
    end
  endtask : drain
endmodule : mer_host_model
`default_nettype wire

// [tb/mer_motion_event_regs_tb_top.sv]
// self-checking bench for the motion and event report registers
`timescale 1ns/1ps
`default_nettype none
module mer_motion_event_regs_tb_top;
  import mer_pkg::*;
  logic              mclk, sys_rst, fp, prdy, rr, rw, rv;
  logic              ce, pgw, pgr, mp, ao; // enable and block outputs
  logic [4:0]        ev;      // motion, reset, wrap, soft, button
  logic signed [7:0] dx, dy;  // frame deltas
  logic [8:0]        fc;      // feature count
  logic [15:0]       ex;      // exposure
  logic [6:0]        ra;      // address from host
  logic [7:0]        rdat, d; // read data
  int                n_fail, checked, cyc, s;
  // small accumulator so the rails are reached in three frames
  mer_motion_event_regs #(.ACC_W(9)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(ce),
    .reg_addr(ra), .reg_rd(rr), .reg_wr(rw), .reg_rdata(rdat), .reg_rvalid(rv),
    .motion_vld(ev[4]), .delta_x_in(dx), .delta_y_in(dy), .feature_count(fc),
    .exposure_in(ex), .pixel_byte_ready(prdy), .pixel_wrap(ev[2]),
    .button_click_evt(ev[0]), .soft_click_evt(ev[1]), .finger_present(fp),
    .int_reset_evt(ev[3]), .pixel_grab_wr(pgw), .pixel_grab_rd(pgr), .motion_pending(mp),
    .accum_overflow(ao));
  mer_host_model host_u (.mclk(mclk), .reg_addr(ra), .reg_rd(rr), .reg_wr(rw),
    .reg_rdata(rdat), .reg_rvalid(rv));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    cmp(d, e);
  endtask : chk
  task automatic pulse(input logic [4:0] v, input logic [7:0] x);
    @(posedge mclk) ev <= v;
    dx <= x;
    @(posedge mclk) ev <= 5'h00;
  endtask : pulse
  task automatic t_motion();
    @(posedge mclk) dy <= -8'sd3;
    pulse(5'h10, 8'h05);
    chk(ADDR_EVENT, 8'h80);
    chk(ADDR_XDISP, 8'h05);
    chk(ADDR_YDISP, 8'hFD);
    chk(ADDR_EVENT, 8'h00);
    @(posedge mclk) dy <= 8'sd0;
  endtask : t_motion
  // three full frames pass the 9-bit rail
  task automatic t_accum_overflow();
    repeat (3) pulse(5'h10, 8'h7F);
    chk(ADDR_EVENT, 8'h90);
    cmp({6'h00, mp, ao}, 8'h03);
    host_u.drain(s);
    cmp(8'(s), 8'hFF);
    chk(ADDR_EVENT, 8'h00);
    cmp({6'h00, mp, ao}, 8'h00);
    repeat (3) pulse(5'h10, 8'h7F);
    host_u.wr(ADDR_EVENT);
    chk(ADDR_EVENT, 8'h00);
    chk(ADDR_XDISP, 8'h00);
  endtask : t_accum_overflow
  task automatic t_flags();
    @(posedge mclk) fp <= 1'b1;
    prdy <= 1'b1;
    pulse(5'h07, 8'h00);
    chk(ADDR_EVENT, 8'h67);
    chk(ADDR_BUTTON_ST, 8'h00);
    chk(ADDR_EVENT, 8'h63);
    chk(ADDR_SOFT_TAP_ST, 8'h00);
    chk(ADDR_EVENT, 8'h61);
    chk(ADDR_FINGER_ST, 8'h00);
    chk(ADDR_EVENT, 8'h60);
    chk(ADDR_PIX_GRAB, 8'h00);
    cmp({6'h00, pgw, pgr}, 8'h01);
    chk(ADDR_EVENT, 8'h40);
    @(posedge mclk) prdy <= 1'b0;
    pulse(5'h08, 8'h00);
    host_u.wr(ADDR_PIX_GRAB);
    #1 cmp({6'h00, pgw, pgr}, 8'h02);
    chk(ADDR_EVENT, 8'h28);
    host_u.wr(ADDR_EVENT);
    chk(ADDR_EVENT, 8'h20);
  endtask : t_flags
  task automatic t_misc();
    @(posedge mclk) fc <= 9'h1FF;
    ex <= 16'hABCD;
    chk(ADDR_SURF_QUAL, 8'hA7);
    @(posedge mclk) fc <= 9'h0AA;
    chk(ADDR_SURF_QUAL, 8'h55);
    host_u.rd(ADDR_EXP_HI, d);
    @(posedge mclk) ex <= 16'h1234;
    cmp(d, 8'hAB);
    chk(ADDR_EXP_LO, 8'hCD);
    chk(7'h10, 8'h00);
  endtask : t_misc
  // enable low: a motion frame must leave no trace
  task automatic t_freeze();
    @(posedge mclk) ce <= 1'b0;
    pulse(5'h10, 8'h05);
    @(posedge mclk) ce <= 1'b1;
    chk(ADDR_EVENT, 8'h20);
    cmp({6'h00, mp, ao}, 8'h00);
  endtask : t_freeze
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    {sys_rst, fp, prdy, ev, dx, dy, fc, ex} = '0;
    {n_fail, checked, cyc} = '0;
    ce = 1'b1;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    chk(ADDR_EVENT, 8'h08);
    host_u.wr(ADDR_EVENT);
    chk(ADDR_EVENT, 8'h00);
    t_motion();
    t_accum_overflow();
    t_flags();
    t_misc();
    t_freeze();
    close_out();
  end
endmodule : mer_motion_event_regs_tb_top
`default_nettype wire
